// ---- hdl/async_serial_status_irq.sv ----
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module async_serial_status_irq #(
  parameter bit CHANNEL0 = 1'b1 // pin functions exist on channel 0 only
) (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rst_i, // async reset, active high
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after strobe
  input wire serial_stat_pkg::rx_char_t rx_char_i, // assembled character
  input wire logic tx_load_i, // shift register takes holding byte
  output logic [7:0] tx_data_o, // holding register contents
  output logic tx_holding_valid_o, // holding register loaded
  input wire logic io_halt_mode_i, // I/O halt mode
  input wire logic dma_rx_route_i, // a DMA channel routes rx data
  input wire logic carrier_detect_n_i, // carrier detect pin
  input wire logic clear_to_send_n_i, // clear-to-send pin
  output logic rx_hold_o, // receiver held in reset
  output logic irq_o // interrupt request, level
);
  typedef struct packed {
    logic cd_s1;
    logic cd_s2;
    logic cd_prev;
    logic cts_s1;
    logic cts_s2;
    logic ovr;
    logic pe;
    logic fe;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic cd_flag;
    logic cd_rise;
    logic lock;
    logic head_chk;
    logic hold_full;
    logic tx_holding_empty_prev;
    logic ready_prev;
    logic [7:0] hold;
    logic [4:0] ctrl;
    logic [serial_stat_pkg::EV_W-1:0] ev;
    logic [serial_stat_pkg::EV_W-1:0] mask;
    logic [7:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  serial_stat_pkg::rx_entry_t head;
  serial_stat_pkg::rx_entry_t new_entry;
  logic [2:0] q_count;
  logic q_push;
  logic q_pop;
  logic q_mark;
  logic rx_ready;
  logic tx_holding_empty;
  logic rx_hold;
  logic efr_wr;
  logic [7:0] status;
  logic [serial_stat_pkg::EV_W-1:0] ev_set;
  logic rx_req;
  logic tx_req;

  //------------------------------------------------------------
  // receive path
  //------------------------------------------------------------
  // carrier holds receiver
  assign rx_hold = io_halt_mode_i || (CHANNEL0 &&
    st_ff.ctrl[serial_stat_pkg::CT_CD_AUTO] && st_ff.cd_s2);
  assign efr_wr = wr_i && addr_i == serial_stat_pkg::ADDR_CTRL &&
    wdata_i[serial_stat_pkg::CT_EFR];

  always_comb begin
    new_entry.data = rx_char_i.data;
    new_entry.pe = st_ff.ctrl[serial_stat_pkg::CT_PAR_EN] &&
      ((^rx_char_i.data ^ rx_char_i.parity) !=
       st_ff.ctrl[serial_stat_pkg::CT_PAR_ODD]);
    new_entry.fe = !rx_char_i.stop;
    new_entry.ovr = 1'b0;
  end

  assign q_push = rx_char_i.valid && !rx_hold && !st_ff.lock &&
    q_count != serial_stat_pkg::QUEUE_FULL;
  // tag last good char on overflow
  assign q_mark = rx_char_i.valid && !rx_hold && !st_ff.lock &&
    q_count == serial_stat_pkg::QUEUE_FULL;
  assign q_pop = rd_i && addr_i == serial_stat_pkg::ADDR_RX_DATA;

  rx_char_queue u_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(rx_hold),
    .push_i(q_push),
    .entry_i(new_entry),
    .pop_i(q_pop),
    .mark_ovr_i(q_mark),
    .head_o(head),
    .count_o(q_count)
  );

  // ready while queue holds a char
  assign rx_ready = q_count != 3'h0;

  //------------------------------------------------------------
  // transmit path
  //------------------------------------------------------------
  // clear-to-send forces empty low; halt mode forces it high
  assign tx_holding_empty = io_halt_mode_i || (!st_ff.hold_full && !(CHANNEL0 &&
    st_ff.ctrl[serial_stat_pkg::CT_CTS_AUTO] && st_ff.cts_s2));

  assign status = {rx_ready, st_ff.ovr, st_ff.pe, st_ff.fe, st_ff.rx_irq_enable,
    st_ff.cd_flag, tx_holding_empty, st_ff.tx_irq_enable};

  //------------------------------------------------------------
  // interrupts
  //------------------------------------------------------------
  // ready irq unless DMA owns data
  assign rx_req = st_ff.rx_irq_enable && ((rx_ready && !dma_rx_route_i) ||
    st_ff.ovr || st_ff.pe || st_ff.fe || st_ff.cd_rise);
  assign tx_req = st_ff.tx_irq_enable && tx_holding_empty;
  assign irq_o = rx_req || tx_req || |(st_ff.ev & st_ff.mask);

  always_comb begin
    ev_set = '0;
    ev_set[serial_stat_pkg::EV_READY] = rx_ready && !st_ff.ready_prev;
    ev_set[serial_stat_pkg::EV_TX_HOLDING_EMPTY] = tx_holding_empty && !st_ff.tx_holding_empty_prev;
    ev_set[serial_stat_pkg::EV_CD_RISE] = CHANNEL0 && st_ff.cd_s2 &&
      !st_ff.cd_prev;
    if (st_ff.head_chk && rx_ready && !rx_hold) begin
      ev_set[serial_stat_pkg::EV_OVR] = head.ovr;
      ev_set[serial_stat_pkg::EV_PE] = head.pe;
      ev_set[serial_stat_pkg::EV_FE] = head.fe;
    end
  end

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cd_s1 = carrier_detect_n_i;
    nxt_st.cd_s2 = st_ff.cd_s1;
    nxt_st.cd_prev = st_ff.cd_s2;
    nxt_st.cts_s1 = clear_to_send_n_i;
    nxt_st.cts_s2 = st_ff.cts_s1;
    nxt_st.tx_holding_empty_prev = tx_holding_empty;
    nxt_st.ready_prev = rx_ready;
    // head changes: check the new head next cycle
    if (q_pop && rx_ready) begin
      nxt_st.head_chk = q_count > 3'h1 || q_push;
    end else begin
      nxt_st.head_chk = q_push && !rx_ready;
    end
    if (efr_wr) begin
      nxt_st.ovr = 1'b0;
      nxt_st.pe = 1'b0;
      nxt_st.fe = 1'b0;
    end
    // flags when char heads; set wins
    nxt_st.ovr = nxt_st.ovr || ev_set[serial_stat_pkg::EV_OVR];
    nxt_st.pe = nxt_st.pe || ev_set[serial_stat_pkg::EV_PE];
    nxt_st.fe = nxt_st.fe || ev_set[serial_stat_pkg::EV_FE];
    if (q_mark) begin
      nxt_st.lock = 1'b1;
    end else if (efr_wr && st_ff.ovr) begin
      nxt_st.lock = 1'b0;
    end
    // halt and carrier clear receive state
    if (rx_hold) begin
      nxt_st.ovr = 1'b0;
      nxt_st.pe = 1'b0;
      nxt_st.fe = 1'b0;
      nxt_st.lock = 1'b0;
      nxt_st.head_chk = 1'b0;
    end
    // carrier flag follows pin, read clears
    if (rd_i && addr_i == serial_stat_pkg::ADDR_STATUS) begin
      nxt_st.cd_flag = 1'b0;
      nxt_st.cd_rise = 1'b0;
    end
    if (CHANNEL0 && st_ff.cd_s2) begin
      nxt_st.cd_flag = 1'b1;
    end
    if (ev_set[serial_stat_pkg::EV_CD_RISE]) begin
      nxt_st.cd_rise = 1'b1;
    end
    // tx_load_i sets empty, a data write clears it
    if (tx_load_i) begin
      nxt_st.hold_full = 1'b0;
    end
    if (wr_i && addr_i == serial_stat_pkg::ADDR_TX_DATA) begin
      nxt_st.hold_full = 1'b1;
      nxt_st.hold = wdata_i;
    end
    if (io_halt_mode_i) begin
      nxt_st.hold_full = 1'b0;
    end
    if (wr_i && addr_i == serial_stat_pkg::ADDR_STATUS) begin
      nxt_st.rx_irq_enable = wdata_i[serial_stat_pkg::ST_RIE];
      nxt_st.tx_irq_enable = wdata_i[serial_stat_pkg::ST_TIE];
    end
    if (wr_i && addr_i == serial_stat_pkg::ADDR_CTRL) begin
      nxt_st.ctrl = {wdata_i[4:1], 1'b0};
    end
    if (wr_i && addr_i == serial_stat_pkg::ADDR_IRQ_MASK) begin
      nxt_st.mask = wdata_i[serial_stat_pkg::EV_W-1:0];
    end
    // sticky events: a read clears, a set in that cycle wins
    if (rd_i && addr_i == serial_stat_pkg::ADDR_IRQ_STAT) begin
      nxt_st.ev = '0;
    end
    nxt_st.ev = nxt_st.ev | ev_set;
    // read data stands only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == serial_stat_pkg::ADDR_STATUS) begin
        nxt_st.rdata = status;
      end else if (addr_i == serial_stat_pkg::ADDR_CTRL) begin
        nxt_st.rdata = {3'h0, st_ff.ctrl};
      end else if (addr_i == serial_stat_pkg::ADDR_RX_DATA) begin
        nxt_st.rdata = rx_ready ? head.data : 8'h00;
      end else if (addr_i == serial_stat_pkg::ADDR_TX_DATA) begin
        nxt_st.rdata = st_ff.hold;
      end else if (addr_i == serial_stat_pkg::ADDR_IRQ_STAT) begin
        nxt_st.rdata = {2'h0, st_ff.ev};
      end else if (addr_i == serial_stat_pkg::ADDR_IRQ_MASK) begin
        nxt_st.rdata = {2'h0, st_ff.mask};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.ctrl <= serial_stat_pkg::CTRL_RST;
      st_ff.mask <= serial_stat_pkg::IRQ_MASK_RST;
      st_ff.tx_holding_empty_prev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign tx_data_o = st_ff.hold;
  assign tx_holding_valid_o = st_ff.hold_full;
  assign rx_hold_o = rx_hold;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  sequence s_push_empty;
    q_push && !rx_ready;
  endsequence

  sequence s_tx_write;
    wr_i && addr_i == serial_stat_pkg::ADDR_TX_DATA && !io_halt_mode_i;
  endsequence

  property p_ready_set;
    @(posedge clk_i) disable iff (rst_i)
      s_push_empty |=> rx_ready ##0 status[serial_stat_pkg::ST_READY];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready not set after push into empty queue");

  property p_err_queued;
    @(posedge clk_i) disable iff (rst_i)
      rx_char_i.valid && !rx_char_i.stop && !rx_hold && !st_ff.lock &&
      !rx_ready |=> rx_ready ##0 head.fe;
  endproperty
  a_err_queued: assert property (p_err_queued)
    else $error("framing error character not queued");

  property p_hold_clears;
    @(posedge clk_i) disable iff (rst_i)
      rx_hold |=> !rx_ready && !st_ff.ovr && !st_ff.pe && !st_ff.fe;
  endproperty
  a_hold_clears: assert property (p_hold_clears)
    else $error("receive state survived halt or carrier loss");

  property p_efr_clears;
    @(posedge clk_i) disable iff (rst_i)
      efr_wr && !st_ff.head_chk |=> !st_ff.ovr && !st_ff.pe && !st_ff.fe;
  endproperty
  a_efr_clears: assert property (p_efr_clears)
    else $error("error flags not cleared by clear bit");

  property p_drop_locked;
    @(posedge clk_i) disable iff (rst_i)
      st_ff.lock && !q_pop && !rx_hold |=> $stable(q_count);
  endproperty
  a_drop_locked: assert property (p_drop_locked)
    else $error("character queued while overrun lock held");

  property p_cd_follow;
    @(posedge clk_i) disable iff (rst_i)
      CHANNEL0 && st_ff.cd_s2 |=> st_ff.cd_flag;
  endproperty
  a_cd_follow: assert property (p_cd_follow)
    else $error("carrier flag low while pin high");

  property p_tx_write;
    @(posedge clk_i) disable iff (rst_i)
      s_tx_write |=> !tx_holding_empty ##0 tx_holding_valid_o;
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("holding empty still set after write");

  property p_halt_empty;
    @(posedge clk_i) disable iff (rst_i)
      io_halt_mode_i |-> tx_holding_empty ##1 !tx_holding_valid_o;
  endproperty
  a_halt_empty: assert property (p_halt_empty)
    else $error("holding empty not forced in halt mode");

  property p_cts_block;
    @(posedge clk_i) disable iff (rst_i)
      CHANNEL0 && st_ff.ctrl[serial_stat_pkg::CT_CTS_AUTO] &&
      st_ff.cts_s2 && !io_halt_mode_i |-> !tx_holding_empty;
  endproperty
  a_cts_block: assert property (p_cts_block)
    else $error("holding empty set while clear-to-send negated");

  property p_tx_irq;
    @(posedge clk_i) disable iff (rst_i)
      st_ff.tx_irq_enable && tx_holding_empty |-> irq_o;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit interrupt missing");
endmodule
`default_nettype wire

// ---- hdl/serial_stat_pkg.sv ----
//------------------------------------------------------------
//------------------------------------------------------------
`default_nettype none
package serial_stat_pkg;
  // register indexes on the plain port
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_RX_DATA = 3'h2;
  localparam logic [2:0] ADDR_TX_DATA = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
  // status field positions
  localparam int ST_READY = 7;
  localparam int ST_OVR = 6;
  localparam int ST_PE = 5;
  localparam int ST_FE = 4;
  localparam int ST_RIE = 3;
  localparam int ST_CD = 2;
  localparam int ST_TX_HOLDING_EMPTY = 1;
  localparam int ST_TIE = 0;
  // control field positions
  localparam int CT_EFR = 0;
  localparam int CT_PAR_EN = 1;
  localparam int CT_PAR_ODD = 2;
  localparam int CT_CD_AUTO = 3;
  localparam int CT_CTS_AUTO = 4;
  // event positions in the interrupt status register
  localparam int EV_READY = 0;
  localparam int EV_OVR = 1;
  localparam int EV_PE = 2;
  localparam int EV_FE = 3;
  localparam int EV_CD_RISE = 4;
  localparam int EV_TX_HOLDING_EMPTY = 5;
  localparam int EV_W = 6;
  // values after reset
  localparam logic [4:0] CTRL_RST = 5'h18;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 6'h00;
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_FULL = 3'h4;

  typedef struct packed {
    logic [7:0] data;
    logic pe;
    logic fe;
    logic ovr;
  } rx_entry_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity;
    logic stop;
  } rx_char_t;
endpackage
`default_nettype wire

// ---- hdl/rx_char_queue.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_char_queue (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // async reset
  input wire logic flush_i, // drop all entries
  input wire logic push_i, // append an entry
  input wire serial_stat_pkg::rx_entry_t entry_i, // entry to append
  input wire logic pop_i, // remove head
  input wire logic mark_ovr_i, // tag newest entry as last before overrun
  output serial_stat_pkg::rx_entry_t head_o, // oldest entry
  output logic [2:0] count_o // entries held
);
  typedef struct packed {
    serial_stat_pkg::rx_entry_t [serial_stat_pkg::QUEUE_DEPTH-1:0] mem;
    logic [1:0] wr;
    logic [1:0] rd;
    logic [2:0] count;
  } queue_state_t;

  queue_state_t st_ff;
  queue_state_t nxt_st;
  logic do_pop;
  logic do_push;

  always_comb begin
    nxt_st = st_ff;
    do_pop = pop_i && (st_ff.count != 3'h0);
    do_push = push_i && (st_ff.count != serial_stat_pkg::QUEUE_FULL);
    if (mark_ovr_i && st_ff.count != 3'h0) begin
      nxt_st.mem[st_ff.wr - 2'h1].ovr = 1'b1;
    end
    if (do_push) begin
      nxt_st.mem[st_ff.wr] = entry_i;
      nxt_st.wr = st_ff.wr + 2'h1;
    end
    if (do_pop) begin
      nxt_st.rd = st_ff.rd + 2'h1;
    end
    nxt_st.count = st_ff.count + {2'h0, do_push} - {2'h0, do_pop};
    if (flush_i) begin
      nxt_st.wr = 2'h0;
      nxt_st.rd = 2'h0;
      nxt_st.count = 3'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign head_o = st_ff.mem[st_ff.rd];
  assign count_o = st_ff.count;
endmodule
`default_nettype wire

// ---- verif/serial_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// far end: remote transmitter and receiver of the channel
// ------------------------------------------------------------
module serial_far_end (
  input wire logic clk_i, // system clock
  input wire logic accept_i, // far receiver may take a byte
  input wire logic tx_holding_valid_i, // holding register loaded
  input wire logic [7:0] tx_data_i, // holding register contents
  output serial_stat_pkg::rx_char_t rx_char_o, // assembled character
  output logic tx_load_o, // shift register takes the byte
  output logic [7:0] last_tx_o // last byte taken
);
  initial begin
    rx_char_o = '0;
    tx_load_o = 1'b0;
    last_tx_o = 8'h00;
  end

  // one pulse per character; idle fields carry the inverse so a stale
  // value can never pass for a fresh character
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge clk_i);
    rx_char_o <= '{valid: 1'b1, data: d, parity: p, stop: s};
    @(posedge clk_i);
    rx_char_o <= '{valid: 1'b0, data: ~d, parity: ~p, stop: ~s};
  endtask

  // a stalled far end leaves the byte sitting in the holding register
  always @(posedge clk_i) begin
    tx_load_o <= accept_i & tx_holding_valid_i & ~tx_load_o;
    if (tx_load_o) begin
      last_tx_o <= tx_data_i;
    end
  end
endmodule
`default_nettype wire

// ---- verif/async_serial_status_irq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module async_serial_status_irq_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic io_halt_mode_i = 1'b0;
  logic dma_rx_route_i = 1'b0;
  logic carrier_detect_n_i = 1'b0;
  logic clear_to_send_n_i = 1'b0;
  logic accept = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] tx_data_o;
  logic [7:0] last_tx;
  logic [7:0] got;
  logic tx_holding_valid_o;
  logic rx_hold_o;
  logic irq_o;
  logic tx_load;
  serial_stat_pkg::rx_char_t rx_char;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  async_serial_status_irq #(.CHANNEL0(1'b1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_char_i(rx_char),
    .tx_load_i(tx_load), .tx_data_o(tx_data_o),
    .tx_holding_valid_o(tx_holding_valid_o),
    .io_halt_mode_i(io_halt_mode_i), .dma_rx_route_i(dma_rx_route_i),
    .carrier_detect_n_i(carrier_detect_n_i),
    .clear_to_send_n_i(clear_to_send_n_i), .rx_hold_o(rx_hold_o),
    .irq_o(irq_o)
  );

  serial_far_end far (
    .clk_i(clk_i), .accept_i(accept),
    .tx_holding_valid_i(tx_holding_valid_o), .tx_data_i(tx_data_o),
    .rx_char_o(rx_char), .tx_load_o(tx_load), .last_tx_o(last_tx)
  );

  // ------------------------------------------------------------
  // compares and bus cycles
  // ------------------------------------------------------------
  task automatic chk8(input string w, input logic [7:0] e,
                      input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic chk1(input string w, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %b seen %b", w, e, s);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string w, input logic [2:0] a,
                       input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
    chk8(w, e, got);
  endtask

  task automatic st(input logic [7:0] e);
    rdchk("status", serial_stat_pkg::ADDR_STATUS, e);
  endtask

  task automatic rx(input logic [7:0] e);
    rdchk("rx data", serial_stat_pkg::ADDR_RX_DATA, e);
  endtask

  task automatic ctl(input logic [7:0] v);
    wr(serial_stat_pkg::ADDR_CTRL, v);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    st(8'h02); // reset values
    rdchk("ctrl", serial_stat_pkg::ADDR_CTRL, 8'h18); // even, off
    rdchk("mask", serial_stat_pkg::ADDR_IRQ_MASK, 8'h00); // none
    wr(3'h7, 8'hff);
    rdchk("unmapped", 3'h7, 8'h00); // no stray state
    st(8'h02); // still empty
    rx(8'h00); // empty queue
    chk1("irq", 1'b0, irq_o); // nothing pending
  endtask

  task automatic t_overrun();
    for (int i = 0; i < 5; i++) far.send(8'ha0 + i[7:0], 1'b0, 1'b1);
    wait_cyc(3);
    st(8'h82); // flag waits for head
    rx(8'ha0); // oldest first
    rx(8'ha1); // order kept
    rx(8'ha2); // order kept
    wait_cyc(3);
    st(8'hc2); // last good char heads
    rx(8'ha3); // depth four
    far.send(8'hb0, 1'b0, 1'b1);
    wait_cyc(3);
    st(8'h42); // locked, dropped
    ctl(8'h19); // clear bit
    st(8'h02); // flag cleared
    far.send(8'hb1, 1'b0, 1'b1);
    wait_cyc(3);
    st(8'h82); // queuing resumes
    rx(8'hb1); // resumed char
  endtask

  task automatic t_parity();
    logic [7:0] d;
    d = 8'h35;
    for (int odd = 0; odd < 2; odd++) begin
      ctl({3'h0, 2'b11, odd[0], 2'b10});
      far.send(d, ^d ^ odd[0] ^ 1'b1, 1'b1);
      wait_cyc(3);
      st(8'ha2); // bad parity
      rx(d); // errored char kept
      ctl({3'h0, 2'b11, odd[0], 2'b11});
      far.send(d, ^d ^ odd[0], 1'b0);
      wait_cyc(3);
      st(8'h92); // framing only
      rx(d); // errored char kept
      ctl({3'h0, 2'b11, odd[0], 2'b11});
    end
    ctl(8'h18);
  endtask

  task automatic t_tx();
    wr(serial_stat_pkg::ADDR_TX_DATA, 8'h5a);
    wait_cyc(1);
    chk1("holding valid", 1'b1, tx_holding_valid_o); // write
    chk8("holding data", 8'h5a, tx_data_o); // byte held
    st(8'h00); // empty clears
    @(posedge clk_i);
    accept <= 1'b1;
    wait_cyc(5);
    chk8("far byte", 8'h5a, last_tx); // byte moved
    st(8'h02); // empty again
    @(posedge clk_i);
    clear_to_send_n_i <= 1'b1;
    wait_cyc(4);
    st(8'h00); // send blocked
    @(posedge clk_i);
    clear_to_send_n_i <= 1'b0;
    far.send(8'h11, 1'b0, 1'b1);
    wait_cyc(3);
    @(posedge clk_i);
    io_halt_mode_i <= 1'b1;
    wait_cyc(2);
    chk1("rx hold", 1'b1, rx_hold_o); // halt holds receiver
    st(8'h02); // halt values
    wr(serial_stat_pkg::ADDR_TX_DATA, 8'h33);
    wait_cyc(1);
    chk1("holding valid", 1'b0, tx_holding_valid_o); // halt
    @(posedge clk_i);
    io_halt_mode_i <= 1'b0;
    rx(8'h00); // queue emptied
  endtask

  task automatic t_irq();
    wr(serial_stat_pkg::ADDR_STATUS, 8'h01);
    wait_cyc(1);
    chk1("irq", 1'b1, irq_o); // holding empty
    wr(serial_stat_pkg::ADDR_STATUS, 8'h08);
    wait_cyc(1);
    chk1("irq", 1'b0, irq_o); // nothing pending
    far.send(8'h22, 1'b0, 1'b1);
    wait_cyc(3);
    chk1("irq", 1'b1, irq_o); // data ready
    @(posedge clk_i);
    dma_rx_route_i <= 1'b1;
    wait_cyc(1);
    chk1("irq", 1'b0, irq_o); // dma takes data
    @(posedge clk_i);
    dma_rx_route_i <= 1'b0;
    rx(8'h22); // byte read
    far.send(8'h00, 1'b0, 1'b0);
    wait_cyc(3);
    chk1("irq", 1'b1, irq_o); // framing error
    rx(8'h00); // errored char kept
    wait_cyc(1);
    chk1("irq", 1'b1, irq_o); // error still pending
    ctl(8'h19);
    wait_cyc(1);
    chk1("irq", 1'b0, irq_o); // all cleared
    wr(serial_stat_pkg::ADDR_STATUS, 8'h00);
    // every event but carrier rise has fired since reset
    rdchk("irq flush", serial_stat_pkg::ADDR_IRQ_STAT, 8'h2f);
    wr(serial_stat_pkg::ADDR_IRQ_MASK, 8'h01);
    far.send(8'h44, 1'b0, 1'b1);
    wait_cyc(3);
    chk1("irq", 1'b1, irq_o); // masked event
    rdchk("irq status", serial_stat_pkg::ADDR_IRQ_STAT, 8'h01);
    wait_cyc(1);
    chk1("irq", 1'b0, irq_o); // read clears
    rx(8'h44); // byte read
    wr(serial_stat_pkg::ADDR_IRQ_MASK, 8'h00);
  endtask

  task automatic t_carrier();
    wr(serial_stat_pkg::ADDR_STATUS, 8'h08);
    far.send(8'h55, 1'b0, 1'b1);
    wait_cyc(3);
    @(posedge clk_i);
    carrier_detect_n_i <= 1'b1;
    wait_cyc(4);
    chk1("rx hold", 1'b1, rx_hold_o); // carrier lost
    chk1("irq", 1'b1, irq_o); // carrier rise
    st(8'h0e); // ready gone, flag up
    wait_cyc(1);
    chk1("irq", 1'b0, irq_o); // rise taken
    @(posedge clk_i);
    carrier_detect_n_i <= 1'b0;
    wait_cyc(4);
    chk1("rx hold", 1'b0, rx_hold_o); // released
    st(8'h0e); // flag until read
    st(8'h0a); // cleared by read
    rx(8'h00); // queue reset
    wr(serial_stat_pkg::ADDR_STATUS, 8'h00);
  endtask

  // ------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_overrun();
    t_parity();
    t_tx();
    t_irq();
    t_carrier();
    end_sim();
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      $display("FAIL timeout expected done seen hang");
      end_sim();
    end
  end
endmodule
`default_nettype wire
